// >>> core/pcs_core.sv
/*
 * Program counter sequencer: low byte, high latch, paging and return stack.
 * Assumes the decoder presents one operation per cycle, synchronous to i_clk.
 */
`timescale 1ns/1ps
module pcs_core (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Decoder operation
    input wire pcs_pkg::pcs_op_t i_op,
    input wire logic [10:0] i_target,
    input wire logic [7:0] i_low_wdata,
    // High latch write
    input wire logic i_latch_we,
    input wire logic [4:0] i_latch_wdata,
    // Program counter and readable state
    output logic [12:0] o_pc,
    output logic [7:0] o_pc_low,
    output logic [4:0] o_latch
);
    // ==========================================================
    // Registered state
    logic [1:0] pc_page;
    logic [2:0] pc_mid;
    logic [7:0] pc_byte;
    logic [4:0] latch;
    logic [12:0] pc;

    // ==========================================================
    // Decode flags, exactly one high in any cycle
    logic op_next;
    logic op_wrlow;
    logic op_branch;
    logic op_call;
    logic op_ret;
    logic op_irq;
    logic op_hold;
    logic op_spare;

    // ==========================================================
    // Candidate addresses
    logic [12:0] seq_addr;
    logic [12:0] low_addr;
    logic [12:0] page_addr;
    logic [12:0] ret_addr;
    logic [12:0] vec_addr;

    // ==========================================================
    // Next state
    logic [7:0] next_pc_byte;
    logic [2:0] next_pc_mid;
    logic [1:0] next_pc_page;
    logic [12:0] next_pc;
    logic [4:0] next_latch;

    // ==========================================================
    // Stack side
    logic push;
    logic pop;
    logic [12:0] push_data;
    logic [12:0] stack_top;

    // ==========================================================
    // Operation decode; code 4 is unused and behaves as hold
    // One-hot flags keep the selectors below free of priority
    always_comb begin
        op_next = 1'b0;
        op_wrlow = 1'b0;
        op_branch = 1'b0;
        op_call = 1'b0;
        op_ret = 1'b0;
        op_irq = 1'b0;
        op_hold = 1'b0;
        op_spare = 1'b0;
        unique case (i_op)
            pcs_pkg::PCS_OP_NEXT: begin
                op_next = 1'b1;
            end
            pcs_pkg::PCS_OP_WRLOW: begin
                op_wrlow = 1'b1;
            end
            pcs_pkg::PCS_OP_BRANCH: begin
                op_branch = 1'b1;
            end
            pcs_pkg::PCS_OP_CALL: begin
                op_call = 1'b1;
            end
            pcs_pkg::PCS_OP_RET: begin
                op_ret = 1'b1;
            end
            pcs_pkg::PCS_OP_IRQ: begin
                op_irq = 1'b1;
            end
            pcs_pkg::PCS_OP_HOLD: begin
                op_hold = 1'b1;
            end
            default: begin
                op_spare = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // Candidate addresses
    assign pc = {pc_page, pc_mid, pc_byte};
    assign seq_addr = 13'(pc + 13'h0001);
    // No carry out of the low byte: the latch alone sets the top
    assign low_addr = {latch, i_low_wdata};
    assign page_addr = {latch[pcs_pkg::PAGE_HI:pcs_pkg::PAGE_LO], i_target};
    assign ret_addr = stack_top;
    assign vec_addr = pcs_pkg::IRQ_VECTOR;

    // ==========================================================
    // Stack control
    assign push = op_call | op_irq;
    assign pop = op_ret;

    // Irq saves the interrupted address, call the one after it
    always_comb begin
        if (op_irq) begin
            push_data = pc;
        end else begin
            push_data = seq_addr;
        end
    end

    // Pointer is hidden and wraps silently in both directions
    // Push and pop never meet: one operation per cycle
    pcs_stack #(
        .DEPTH(pcs_pkg::STACK_DEPTH),
        .WIDTH(pcs_pkg::PC_W)
    ) u_stack (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_push(push),
        .i_pop(pop),
        .i_data(push_data),
        .o_top(stack_top)
    );

    // ==========================================================
    // Next low byte
    always_comb begin
        next_pc_byte = pc_byte;
        unique case (1'b1)
            op_next: begin
                next_pc_byte = seq_addr[7:0];
            end
            op_wrlow: begin
                next_pc_byte = low_addr[7:0];
            end
            op_branch,
            op_call: begin
                next_pc_byte = page_addr[7:0];
            end
            op_ret: begin
                next_pc_byte = ret_addr[7:0];
            end
            op_irq: begin
                next_pc_byte = vec_addr[7:0];
            end
            op_hold,
            op_spare: begin
                next_pc_byte = pc_byte;
            end
        endcase
    end

    // ==========================================================
    // Next bits 10 to 8, inside the page
    always_comb begin
        next_pc_mid = pc_mid;
        unique case (1'b1)
            op_next: begin
                next_pc_mid = seq_addr[10:8];
            end
            op_wrlow: begin
                next_pc_mid = low_addr[10:8];
            end
            op_branch,
            op_call: begin
                next_pc_mid = page_addr[10:8];
            end
            op_ret: begin
                next_pc_mid = ret_addr[10:8];
            end
            op_irq: begin
                next_pc_mid = vec_addr[10:8];
            end
            op_hold,
            op_spare: begin
                next_pc_mid = pc_mid;
            end
        endcase
    end

    // ==========================================================
    // Next page bits
    always_comb begin
        next_pc_page = pc_page;
        unique case (1'b1)
            op_next: begin
                next_pc_page = seq_addr[12:11];
            end
            op_wrlow: begin
                next_pc_page = low_addr[12:11];
            end
            op_branch,
            op_call: begin
                next_pc_page = page_addr[12:11];
            end
            op_ret: begin
                next_pc_page = ret_addr[12:11];
            end
            op_irq: begin
                next_pc_page = vec_addr[12:11];
            end
            op_hold,
            op_spare: begin
                next_pc_page = pc_page;
            end
        endcase
    end

    // ==========================================================
    // Full next address
    assign next_pc = {next_pc_page, next_pc_mid, next_pc_byte};

    // ==========================================================
    // Next latch; stack traffic never touches it
    always_comb begin
        next_latch = latch;
        if (i_latch_we) begin
            next_latch = i_latch_wdata;
        end
    end

    // ==========================================================
    // Program counter registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_byte <= pcs_pkg::PC_RESET[7:0];
        end else begin
            pc_byte <= next_pc_byte;
        end
    end

    // Upper bits cleared by every reset, so no stale page survives
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_mid <= pcs_pkg::PC_RESET[10:8];
        end else begin
            pc_mid <= next_pc_mid;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_page <= pcs_pkg::PC_RESET[12:11];
        end else begin
            pc_page <= next_pc_page;
        end
    end

    // ==========================================================
    // High latch
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            latch <= pcs_pkg::LATCH_RESET;
        end else begin
            latch <= next_latch;
        end
    end

    // ==========================================================
    // Fetch address
    // Registered copies cost flops but keep every output glitch-free
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pc <= pcs_pkg::PC_RESET;
        end else begin
            o_pc <= next_pc;
        end
    end

    // ==========================================================
    // Readable low byte; upper bits leave only on the fetch address
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pc_low <= pcs_pkg::PC_RESET[7:0];
        end else begin
            o_pc_low <= next_pc_byte;
        end
    end

    // ==========================================================
    // High latch copy
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_latch <= pcs_pkg::LATCH_RESET;
        end else begin
            o_latch <= next_latch;
        end
    end
endmodule : pcs_core

// >>> core/pcs_pkg.sv
/*
 * Constants and types for the program counter, paging and return stack block.
 * Assumes a single instruction clock; the decoder issues one operation per cycle.
 */
// Function
// - Program counter is thirteen bits wide
// - Low byte readable and writable by software
// - Upper counter bits never directly readable
// - Any reset clears upper counter bits
// - Low byte write loads upper bits from latch
// - Call/goto: eleven instruction bits, latch page bits
// - Eight entry thirteen bit hardware stack
// - Stack pointer is internal only
// - Push on call and interrupt vectoring
// - Pop on return, literal return, interrupt return
// - Push and pop leave latch unchanged
// - Stack wraps circularly, ninth push overwrites first
// - No overflow or underflow status
// - Return restores all thirteen counter bits
// - Returns never reload the high latch
// - Eight K word space in 2K pages
// - Computed jump adds no carry upward
package pcs_pkg;
    // ==========================================================
    // Widths
    localparam int PC_W = 13;
    localparam int LOW_W = 8;
    localparam int LATCH_W = 5;
    localparam int BRANCH_W = 11;
    localparam int STACK_DEPTH = 8;
    localparam int PAGE_LO = 3;
    localparam int PAGE_HI = 4;

    // ==========================================================
    // Reset values and vectors
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [4:0] LATCH_RESET = 5'h00;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;

    // ==========================================================
    // Operations issued by the decoder
    typedef enum logic [2:0] {
        PCS_OP_NEXT = 3'h0,
        PCS_OP_WRLOW = 3'h1,
        PCS_OP_BRANCH = 3'h3,
        PCS_OP_CALL = 3'h2,
        PCS_OP_RET = 3'h6,
        PCS_OP_IRQ = 3'h7,
        PCS_OP_HOLD = 3'h5
    } pcs_op_t;
endpackage : pcs_pkg

// >>> core/pcs_stack.sv
/*
 * Circular return-address stack, flip-flop storage.
 * Assumes push and pop are never asserted together.
 */
`timescale 1ns/1ps
module pcs_stack #(
    parameter int DEPTH = pcs_pkg::STACK_DEPTH,
    parameter int WIDTH = pcs_pkg::PC_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [WIDTH-1:0] i_data,
    // Top of stack
    output logic [WIDTH-1:0] o_top
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] ptr;

    // ==========================================================
    // Pointer: free-running modulo, no full/empty tracking
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ptr <= '0;
        end else if (i_push) begin
            ptr <= ptr + 1'b1;
        end else if (i_pop) begin
            ptr <= ptr - 1'b1;
        end
    end

    // ==========================================================
    // Storage
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (i_push) begin
            mem[ptr] <= i_data;
        end
    end

    // Entry below the pointer is the most recent push
    assign o_top = mem[PW'(ptr - 1'b1)];
endmodule : pcs_stack

// >>> tb/pcs_dec_model.sv
/* Decoder stand-in that issues one sequencer operation per clock.
   Assumes callers step it once per rising edge of i_clk. */
`timescale 1ns/1ps
module pcs_dec_model (
    // Clock
    input wire logic i_clk,
    // Operation to the core
    output pcs_pkg::pcs_op_t o_op,
    output logic [10:0] o_target,
    output logic [7:0] o_low,
    output logic o_we,
    output logic [4:0] o_lat
);
    // ==========================================================
    // Stimulus
    initial begin
        o_op = pcs_pkg::PCS_OP_HOLD;
        {o_target, o_low, o_we, o_lat} = '0;
    end
    task issue(input pcs_pkg::pcs_op_t op, input logic [10:0] t, input logic [7:0] l,
               input logic we, input logic [4:0] d);
        @(posedge i_clk);
        o_op <= op;
        o_target <= t;
        o_low <= l;
        o_we <= we;
        o_lat <= d;
    endtask : issue
endmodule : pcs_dec_model

// >>> tb/pcs_core_asserts.sv
/* Port checker for the program counter sequencer.
   Assumes it is bound into every pcs_core instance. */
`timescale 1ns/1ps
module pcs_core_asserts (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Watched ports
    input wire pcs_pkg::pcs_op_t i_op,
    input wire logic [10:0] i_target,
    input wire logic [7:0] i_low_wdata,
    input wire logic i_latch_we,
    input wire logic [4:0] i_latch_wdata,
    input wire logic [12:0] o_pc,
    input wire logic [7:0] o_pc_low,
    input wire logic [4:0] o_latch
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ==========================================================
    // Sequencing
    low_mirror_a: assert property (o_pc_low == o_pc[7:0])
        else $error("low byte differs from pc");
    wrlow_load_a: assert property (i_op == pcs_pkg::PCS_OP_WRLOW |=>
        o_pc == {$past(o_latch), $past(i_low_wdata)}) else $error("low write target wrong");
    branch_page_a: assert property (i_op == pcs_pkg::PCS_OP_BRANCH |=>
        o_pc == {$past(o_latch[4:3]), $past(i_target)}) else $error("branch target wrong");
    call_page_a: assert property (i_op == pcs_pkg::PCS_OP_CALL |=>
        o_pc == {$past(o_latch[4:3]), $past(i_target)}) else $error("call target wrong");
    irq_vector_a: assert property (i_op == pcs_pkg::PCS_OP_IRQ |=> o_pc == pcs_pkg::IRQ_VECTOR)
        else $error("interrupt vector wrong");
    latch_write_a: assert property (i_latch_we |=> o_latch == $past(i_latch_wdata))
        else $error("latch write lost");
    latch_keep_a: assert property (!i_latch_we |=> $stable(o_latch))
        else $error("latch changed without write");
    next_inc_a: assert property (i_op == pcs_pkg::PCS_OP_NEXT |=>
        o_pc == 13'($past(o_pc) + 1)) else $error("pc did not step");
    call_ret_a: assert property (i_op == pcs_pkg::PCS_OP_CALL ##1 i_op == pcs_pkg::PCS_OP_RET
        |=> o_pc == 13'($past(o_pc, 2) + 1)) else $error("return address wrong");
    cov_call_ret: cover property (i_op == pcs_pkg::PCS_OP_CALL ##1 i_op == pcs_pkg::PCS_OP_RET);
    cov_irq: cover property (i_op == pcs_pkg::PCS_OP_IRQ);
    cov_wrlow: cover property (i_op == pcs_pkg::PCS_OP_WRLOW);
endmodule : pcs_core_asserts
bind pcs_core pcs_core_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_op(i_op),
    .i_target(i_target), .i_low_wdata(i_low_wdata), .i_latch_we(i_latch_we),
    .i_latch_wdata(i_latch_wdata), .o_pc(o_pc), .o_pc_low(o_pc_low), .o_latch(o_latch));

// >>> tb/pcs_core_tb_top.sv
/* Self-checking bench for the program counter sequencer.
   Assumes pcs_dec_model drives every decoder input. */
`timescale 1ns/1ps
module pcs_core_tb_top;
    logic i_clk, i_rst;
    pcs_pkg::pcs_op_t op;
    logic [10:0] tgt;
    logic [7:0] low, pc_low;
    logic we;
    logic [4:0] lat, latch;
    logic [12:0] pc;
    int n_mismatch = 0;
    int cmp_count = 0;
    pcs_dec_model dec (.i_clk(i_clk), .o_op(op), .o_target(tgt), .o_low(low), .o_we(we),
        .o_lat(lat));
    pcs_core dut (.i_clk(i_clk), .i_rst(i_rst), .i_op(op), .i_target(tgt), .i_low_wdata(low),
        .i_latch_we(we), .i_latch_wdata(lat), .o_pc(pc), .o_pc_low(pc_low), .o_latch(latch));
    initial begin
        i_clk = 0;
        forever #4 i_clk = ~i_clk;
    end
    // ==========================================================
    // Checks and tests
    task chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task summarize;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    task t_page;
        dec.issue(pcs_pkg::PCS_OP_HOLD, 0, 0, 1, 5'h08);
        dec.issue(pcs_pkg::PCS_OP_CALL, 11'h100, 0, 0, 0);
        dec.issue(pcs_pkg::PCS_OP_IRQ, 0, 0, 0, 0);
        #1 chk("call pc", pc, 13'h0900);
        dec.issue(pcs_pkg::PCS_OP_RET, 0, 0, 0, 0);
        #1 chk("irq pc", pc, 13'h0004);
        dec.issue(pcs_pkg::PCS_OP_RET, 0, 0, 0, 0);
        #1 chk("irq return", pc, 13'h0900);
        dec.issue(pcs_pkg::PCS_OP_HOLD, 0, 0, 0, 0);
        #1 chk("call return", pc, 13'h0001);
        chk("latch", 13'(latch), 13'h0008);
        $display("test paging done");
    endtask : t_page
    task t_wrlow;
        dec.issue(pcs_pkg::PCS_OP_HOLD, 0, 0, 1, 5'h1f);
        dec.issue(pcs_pkg::PCS_OP_WRLOW, 0, 8'hff, 0, 0);
        dec.issue(pcs_pkg::PCS_OP_NEXT, 0, 0, 0, 0);
        #1 chk("low write pc", pc, 13'h1fff);
        chk("low byte", 13'(pc_low), 13'h00ff);
        $display("test low write done");
    endtask : t_wrlow
    task t_wrap;
        dec.issue(pcs_pkg::PCS_OP_HOLD, 0, 0, 1, 5'h00);
        dec.issue(pcs_pkg::PCS_OP_BRANCH, 11'h7ff, 0, 0, 0);
        for (int i = 0; i < 9; i++) dec.issue(pcs_pkg::PCS_OP_CALL, 11'(32 + 16 * i), 0, 0, 0);
        for (int p = -1; p < 9; p++) begin
            if (p < 8) dec.issue(pcs_pkg::PCS_OP_RET, 0, 0, 0, 0);
            else dec.issue(pcs_pkg::PCS_OP_HOLD, 0, 0, 0, 0);
            #1 if (p >= 0) chk("pop", pc, 13'(33 + 16 * (p < 8 ? 7 - p : 7)));
        end
        $display("test wrap done");
    endtask : t_wrap
    task t_reset;
        dec.issue(pcs_pkg::PCS_OP_HOLD, 0, 0, 1, 5'h18);
        dec.issue(pcs_pkg::PCS_OP_CALL, 11'h7f0, 0, 0, 0);
        dec.issue(pcs_pkg::PCS_OP_HOLD, 0, 0, 0, 0);
        #1 chk("top page pc", pc, 13'h1ff0);
        @(posedge i_clk);
        i_rst <= 1;
        @(posedge i_clk);
        #1 chk("mid reset pc", pc, 13'h0000);
        chk("mid reset low", 13'(pc_low), 13'h0000);
        @(posedge i_clk);
        i_rst <= 0;
        $display("test reset done");
    endtask : t_reset
    initial begin
        i_rst = 1;
        repeat (12) @(posedge i_clk);
        i_rst <= 0;
        @(posedge i_clk);
        #1 chk("reset pc", pc, 13'h0000);
        t_page;
        t_wrlow;
        t_wrap;
        t_reset;
        summarize;
    end
    initial begin
        // Tests need under 100 cycles
        repeat (2000) @(posedge i_clk);
        n_mismatch++;
        summarize;
    end
endmodule : pcs_core_tb_top
